// File: srtc_defs.vh
`ifndef SRTC_DEFS_VH
`define SRTC_DEFS_VH
// ==========================================
// timing, clock at 20 MHz
`define SRTC_CLK_PERIOD_NS 50
`define SRTC_SCL_MAX_KHZ 100
`define SRTC_QUART_NS 5000
`define SRTC_QUART_CYC ((`SRTC_QUART_NS + `SRTC_CLK_PERIOD_NS - 1) / `SRTC_CLK_PERIOD_NS)
`define SRTC_BUF_NS 4700
`define SRTC_BUF_CYC ((`SRTC_BUF_NS + `SRTC_CLK_PERIOD_NS - 1) / `SRTC_CLK_PERIOD_NS)
// ==========================================
// serial bus addressing
`define SRTC_SLAVE_ADDR 8'hD0
`define SRTC_DEV_SIZE 64
// ==========================================
// device map, bcd timekeeping bytes, control byte, then ram
`define SRTC_LOC_SECONDS_COUNT 6'h00
`define SRTC_LOC_MINUTES_COUNT 6'h01
`define SRTC_LOC_HOURS_COUNT 6'h02
`define SRTC_LOC_WEEKDAY_COUNT 6'h03
`define SRTC_LOC_DAY_OF_MONTH_COUNT 6'h04
`define SRTC_LOC_MONTH_COUNT 6'h05
`define SRTC_LOC_YEAR_COUNT 6'h06
`define SRTC_LOC_TRIM_AND_OUTPUT_CONTROL 6'h07
`define SRTC_OSC_HALT_FLAG_BIT 7
`define SRTC_OUT_LEVEL_BIT 7
`define SRTC_FREQ_CHECK_ENABLE_BIT 6
`define SRTC_TRIM_SIGN_BIT 5
`define SRTC_TRIM_MAG_MSB 4
// ==========================================
// avalon register word indices
`define SRTC_REG_CTRL 3'h0
`define SRTC_REG_STATUS 3'h1
`define SRTC_REG_BUFIDX 3'h2
`define SRTC_REG_BUFDATA 3'h3
// ==========================================
// control register fields
`define SRTC_CTRL_GO 0
`define SRTC_CTRL_RD 1
`define SRTC_CTRL_SETPTR 2
`define SRTC_CTRL_CNT_LSB 8
`define SRTC_CTRL_CNT_MSB 14
`define SRTC_CTRL_WADDR_LSB 16
`define SRTC_CTRL_WADDR_MSB 21
// ==========================================
// status register fields
`define SRTC_STAT_BUSY 0
`define SRTC_STAT_DONE 1
`define SRTC_STAT_NACK 2
`define SRTC_STAT_PFABORT 3
`define SRTC_STAT_PF 4
`define SRTC_STAT_PTR_LSB 8
`define SRTC_STAT_PTR_MSB 13
`endif

// File: srtc_sync.v
`default_nettype none
// ==========================================
// two flip-flop synchroniser for pin inputs
module srtc_sync #(
  parameter WIDTH = 3
) (
  // clock and reset
  input wire clock,
  input wire nrst,
  // asynchronous side
  input wire [WIDTH-1:0] async_in,
  // synchronised side
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // srtc_sync
`default_nettype wire

// File: srtc_host.v
`include "srtc_defs.vh"
`default_nettype none
// Function
// [RULE_01] after start, only address pattern 11010000 selects the device
// [RULE_02] device holds 64 bytes: seven time bytes, control, then ram
// [RULE_03] device pointer advances by one after each data byte
// [RULE_04] power fail aborts access, clears pointer, ignores bus inputs
// [RULE_05] the seven clock bytes are bcd with tens and units fields
// [RULE_06] location 0: halt flag bit 7, tens bits 6-4, units 3-0
// [RULE_07] ranges: minutes 00-59, hours 00-23, weekday 01-07, date, month, year
// [RULE_08] control byte: level bit 7, test bit 6, sign 5, magnitude 4-0
// [RULE_09] master starts only while data and clock lines are both high
// [RULE_10] data changes only while clock low; change at clock high is control
// [RULE_11] start is data falling while clock high
// [RULE_12] stop is data rising while clock high, ending the transfer
// [RULE_13] one clock pulse per bit, data sampled in the high phase
// [RULE_14] each transfer opens with start and closes with stop by master
// [RULE_15] eight-bit bytes msb first, then a ninth acknowledge bit
// [RULE_16] receiver drives acknowledge low, master gives its clock pulse
// [RULE_17] addressed device acknowledges every byte it receives
// [RULE_18] master receiver acknowledges every byte except the last of a read
// [RULE_19] acknowledge held low and stable for the whole high phase
// [RULE_20] master ends read with no acknowledge; device releases data line
// [RULE_21] serial clock no faster than 100 kHz
// [RULE_22] bus stays idle at least 4.7 us after stop before new start
// [RULE_23] direction 0 write: next byte loads pointer, later bytes are data
// [RULE_24] on reads pointer advances only when master acknowledges
// [RULE_25] read without word address starts at the held pointer
// [RULE_26] test bit set gives 512 Hz output, else output follows level bit
// [RULE_27] pointer wraps from 63 back to 0
// [RULE_28] time counters advance once per second with bcd carries
module srtc_host #(
  parameter QUART_CYC = `SRTC_QUART_CYC,
  parameter BUF_CYC = `SRTC_BUF_CYC
) (
  // clock and reset
  input wire clock,
  input wire nrst,
  // avalon-mm slave
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // serial bus, open drain
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  // system power-fail indication
  input wire power_fail
);

  // ==========================================
  // constants
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_WAIT = 6'h02;
  localparam [5:0] S_START = 6'h04;
  localparam [5:0] S_BIT = 6'h08;
  localparam [5:0] S_STOP = 6'h10;
  localparam [5:0] S_BUF = 6'h20;
  localparam [1:0] STG_ADDR = 2'h0;
  localparam [1:0] STG_WORD = 2'h1;
  localparam [1:0] STG_DATA = 2'h2;
  localparam [7:0] SLAVE_ADDR = `SRTC_SLAVE_ADDR;
  localparam [15:0] QMAX = QUART_CYC[15:0] - 16'h0001;
  localparam [15:0] BMAX = BUF_CYC[15:0] - 16'h0001;

  // pointer step with wrap at the top of the device
  function [5:0] ptr_inc;
    input [5:0] p;
    begin
      ptr_inc = p + 6'h01; // see [RULE_27]
    end
  endfunction

  // ==========================================
  // pin synchronisers
  wire [2:0] pins_s;
  wire scl_s;
  wire sda_s;
  wire pf_s;

  srtc_sync #(
    .WIDTH(3)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .async_in({power_fail, sda_i, scl_i}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign pf_s = pins_s[2];

  // ==========================================
  // state
  reg [5:0] state;
  reg [1:0] ph;
  reg [15:0] q_cnt;
  reg [3:0] bit_cnt;
  reg [1:0] stage;
  reg rd_phase;
  reg op_read;
  reg op_setptr;
  reg [6:0] cnt_cfg;
  reg [5:0] waddr_cfg;
  reg [6:0] left;
  reg [5:0] xidx;
  reg [5:0] dev_ptr;
  reg [7:0] rx_sh;
  reg got_ack;
  reg busy;
  reg done;
  reg nack;
  reg pf_abort;
  reg [5:0] buf_idx;
  reg [7:0] mem [0:`SRTC_DEV_SIZE-1];
  reg [7:0] byte_out;
  reg [31:0] next_rdata;

  wire in_bits = (state == S_START) || (state == S_BIT) || (state == S_STOP);
  wire tick = in_bits && (q_cnt == QMAX);
  wire buf_end = (state == S_BUF) && (q_cnt == BMAX);
  wire is_rx = (stage == STG_DATA) && op_read;
  wire last_rx = (left == 7'h01);
  wire bit8 = (bit_cnt == 4'h8);
  wire tx_bit = byte_out[3'h7 - bit_cnt[2:0]]; // see [RULE_15]

  // ==========================================
  // register access decode
  wire bus_req = avs_read | avs_write;
  wire acc = bus_req & ~avs_waitrequest;
  wire acc_wr = acc & avs_write;
  wire wr_ctrl = acc_wr & (avs_address == `SRTC_REG_CTRL);
  wire wr_stat = acc_wr & (avs_address == `SRTC_REG_STATUS);
  wire wr_idx = acc_wr & (avs_address == `SRTC_REG_BUFIDX);
  wire wr_data = acc_wr & (avs_address == `SRTC_REG_BUFDATA);
  wire rd_data = acc & avs_read & (avs_address == `SRTC_REG_BUFDATA);
  wire go_req = wr_ctrl & avs_writedata[`SRTC_CTRL_GO] & ~busy & ~pf_s;
  wire clr_done = wr_stat & avs_writedata[`SRTC_STAT_DONE];
  wire clr_nack = wr_stat & avs_writedata[`SRTC_STAT_NACK];
  wire clr_pf = wr_stat & avs_writedata[`SRTC_STAT_PFABORT];
  wire eng_wr = (state == S_BIT) && tick && (ph == 2'h3) && bit8 && is_rx;

  // byte sent on the bus for the current stage
  always @* begin
    case (stage)
      STG_ADDR: byte_out = {SLAVE_ADDR[7:1], rd_phase}; // see [RULE_01]
      STG_WORD: byte_out = {2'h0, waddr_cfg}; // see [RULE_23]
      default: byte_out = mem[xidx];
    endcase
  end

  always @* begin
    next_rdata = 32'h0000_0000;
    case (avs_address)
      `SRTC_REG_CTRL: begin
        next_rdata[`SRTC_CTRL_RD] = op_read;
        next_rdata[`SRTC_CTRL_SETPTR] = op_setptr;
        next_rdata[`SRTC_CTRL_CNT_MSB:`SRTC_CTRL_CNT_LSB] = cnt_cfg;
        next_rdata[`SRTC_CTRL_WADDR_MSB:`SRTC_CTRL_WADDR_LSB] = waddr_cfg;
      end
      `SRTC_REG_STATUS: begin
        next_rdata[`SRTC_STAT_BUSY] = busy;
        next_rdata[`SRTC_STAT_DONE] = done;
        next_rdata[`SRTC_STAT_NACK] = nack;
        next_rdata[`SRTC_STAT_PFABORT] = pf_abort;
        next_rdata[`SRTC_STAT_PF] = pf_s;
        next_rdata[`SRTC_STAT_PTR_MSB:`SRTC_STAT_PTR_LSB] = dev_ptr;
      end
      `SRTC_REG_BUFIDX: next_rdata[5:0] = buf_idx;
      `SRTC_REG_BUFDATA: next_rdata[7:0] = mem[buf_idx];
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // ==========================================
  // avalon handshake: one wait cycle, then the access is taken
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= next_rdata;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // software buffer index and transfer buffer
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      buf_idx <= 6'h00;
    end else if (wr_idx) begin
      buf_idx <= avs_writedata[5:0];
    end else if (wr_data || rd_data) begin
      buf_idx <= ptr_inc(buf_idx);
    end
  end

  always @(posedge clock) begin
    if (eng_wr) begin
      mem[xidx] <= rx_sh;
    end else if (wr_data) begin
      mem[buf_idx] <= avs_writedata[7:0];
    end
  end

  // ==========================================
  // serial bus engine
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
      ph <= 2'h0;
      q_cnt <= 16'h0000;
      bit_cnt <= 4'h0;
      stage <= STG_ADDR;
      rd_phase <= 1'b0;
      op_read <= 1'b0;
      op_setptr <= 1'b0;
      cnt_cfg <= 7'h00;
      waddr_cfg <= 6'h00;
      left <= 7'h00;
      xidx <= 6'h00;
      dev_ptr <= 6'h00;
      rx_sh <= 8'h00;
      got_ack <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
      pf_abort <= 1'b0;
      scl_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      // quarter-bit divider, also times the bus-free gap
      if (!in_bits && state != S_BUF || tick || buf_end) begin
        q_cnt <= 16'h0000;
      end else begin
        q_cnt <= q_cnt + 16'h0001; // see [RULE_21]
      end
      if (clr_done) begin
        done <= 1'b0;
      end
      if (clr_nack) begin
        nack <= 1'b0;
      end
      if (clr_pf) begin
        pf_abort <= 1'b0;
      end
      if (pf_s) begin
        // device drops the access and its pointer; release the bus
        if (busy) begin
          pf_abort <= 1'b1; // see [RULE_04]
          done <= 1'b1;
        end
        dev_ptr <= 6'h00; // see [RULE_04]
        busy <= 1'b0;
        state <= S_IDLE;
        ph <= 2'h0;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            ph <= 2'h0;
            if (go_req) begin
              op_read <= avs_writedata[`SRTC_CTRL_RD];
              op_setptr <= avs_writedata[`SRTC_CTRL_SETPTR];
              cnt_cfg <= avs_writedata[`SRTC_CTRL_CNT_MSB:`SRTC_CTRL_CNT_LSB];
              waddr_cfg <= avs_writedata[`SRTC_CTRL_WADDR_MSB:`SRTC_CTRL_WADDR_LSB];
              left <= avs_writedata[`SRTC_CTRL_CNT_MSB:`SRTC_CTRL_CNT_LSB];
              // a read without word address starts at the held pointer
              rd_phase <= avs_writedata[`SRTC_CTRL_RD] & ~avs_writedata[`SRTC_CTRL_SETPTR]; // see [RULE_25]
              stage <= STG_ADDR;
              xidx <= 6'h00;
              busy <= 1'b1;
              state <= S_WAIT;
            end
          end
          S_WAIT: begin
            if (scl_s && sda_s) begin
              state <= S_START; // see [RULE_09]
            end
          end
          S_START: begin
            if (tick) begin
              ph <= ph + 2'h1;
              case (ph)
                2'h0: sda_oe <= 1'b0;
                2'h1: scl_oe <= 1'b0;
                2'h2: sda_oe <= 1'b1; // see [RULE_11] [RULE_14]
                default: begin
                  scl_oe <= 1'b1;
                  bit_cnt <= 4'h0;
                  state <= S_BIT;
                end
              endcase
            end
          end
          S_BIT: begin
            if (tick) begin
              ph <= ph + 2'h1;
              case (ph)
                2'h0: begin
                  // data moves only while the clock is low
                  if (bit8) begin
                    sda_oe <= is_rx & ~last_rx; // see [RULE_16] [RULE_18] [RULE_20]
                  end else begin
                    sda_oe <= ~is_rx & ~tx_bit; // see [RULE_10]
                  end
                end
                2'h1: scl_oe <= 1'b0; // see [RULE_13] [RULE_19]
                2'h2: begin
                  if (bit8) begin
                    got_ack <= ~sda_s; // see [RULE_17]
                  end else begin
                    rx_sh <= {rx_sh[6:0], sda_s}; // see [RULE_13]
                  end
                end
                default: begin
                  scl_oe <= 1'b1;
                  if (!bit8) begin
                    bit_cnt <= bit_cnt + 4'h1;
                  end else begin
                    bit_cnt <= 4'h0;
                    if (!is_rx && !got_ack) begin
                      nack <= 1'b1;
                      state <= S_STOP;
                    end else begin
                      case (stage)
                        STG_ADDR: begin
                          if (!rd_phase) begin
                            stage <= STG_WORD; // see [RULE_23]
                          end else if (left == 7'h00) begin
                            state <= S_STOP;
                          end else begin
                            stage <= STG_DATA;
                          end
                        end
                        STG_WORD: begin
                          dev_ptr <= waddr_cfg; // see [RULE_23]
                          if (op_read) begin
                            rd_phase <= 1'b1;
                            stage <= STG_ADDR;
                            state <= S_START;
                          end else if (left == 7'h00) begin
                            state <= S_STOP;
                          end else begin
                            stage <= STG_DATA;
                          end
                        end
                        default: begin
                          xidx <= ptr_inc(xidx);
                          left <= left - 7'h01;
                          if (!is_rx || !last_rx) begin
                            dev_ptr <= ptr_inc(dev_ptr); // see [RULE_03] [RULE_24]
                          end
                          if (left == 7'h01) begin
                            state <= S_STOP;
                          end
                        end
                      endcase
                    end
                  end
                end
              endcase
            end
          end
          S_STOP: begin
            if (tick) begin
              ph <= ph + 2'h1;
              case (ph)
                2'h0: sda_oe <= 1'b1;
                2'h1: scl_oe <= 1'b0;
                2'h2: sda_oe <= 1'b0; // see [RULE_12] [RULE_14]
                default: state <= S_BUF;
              endcase
            end
          end
          S_BUF: begin
            if (buf_end) begin
              busy <= 1'b0; // see [RULE_22]
              done <= 1'b1;
              state <= S_IDLE;
            end
          end
          default: begin
            state <= S_IDLE;
            busy <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // srtc_host
`default_nettype wire

// File: srtc_dev_model.sv
`default_nettype none
// ==========================================
// behavioural serial clock/ram device
module srtc_dev_model (
  // bus lines and supply state
  input wire logic scl,
  input wire logic sda,
  input wire logic power_fail,
  // ignore all starts, forces a missing acknowledge
  input wire logic deaf,
  // data line pull-down
  output logic pull
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [64];
  logic [7:0] sh;
  logic [5:0] ptr;
  logic frame, sel, rdm, send, ack_due;
  int bitn, phase;
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 8'(i * 37 + 11);
    // clock bytes start as valid bcd, control with the level bit set
    {mem[0], mem[1], mem[2], mem[3]} = 32'h59_59_23_07;
    {mem[4], mem[5], mem[6], mem[7]} = 32'h31_12_99_80;
    ptr = 6'h0;
    frame = 0;
    send = 0;
    pull = 0;
  end
  always @(posedge power_fail) begin
    frame = 0;
    send = 0;
    ptr = 6'h0;
    pull = 0;
  end
  always @(negedge sda) if (scl === 1'b1 && !power_fail && !deaf) begin
    frame = 1;
    bitn = 0;
    phase = 0;
    sel = 0;
    send = 0;
    ack_due = 0;
  end
  always @(posedge sda) if (scl === 1'b1) frame = 0;
  always @(posedge scl) if (frame && !power_fail) begin
    if (bitn < 8) begin
      sh = {sh[6:0], sda};
      bitn++;
      if (bitn == 8 && !send) begin
        if (phase == 0) begin
          sel = sh[7:1] == 7'h68;
          rdm = sh[0];
        end else if (sel && phase == 1) ptr = sh[5:0];
        else if (sel) begin
          mem[ptr] = sh;
          ptr++;
        end
        phase++;
        ack_due = sel;
      end
    end else begin
      bitn = 0;
      ack_due = 0;
      if (send) begin
        if (sda) send = 0;
        else ptr++;
      end else send = sel && rdm;
    end
  end
  always @(negedge scl) if (frame && !power_fail) begin
    if (bitn == 8 && ack_due) pull = 1;
    else if (send && bitn < 8) pull = !mem[ptr][7 - bitn];
    else pull = 0;
  end
endmodule // srtc_dev_model
`default_nettype wire

// File: srtc_host_asserts.sv
`default_nettype none
module srtc_host_asserts #(
  parameter int QUART_CYC = 100,
  parameter int BUF_CYC = 94
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // serial bus and power
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic power_fail
);
  timeunit 1ns;
  timeprecision 1ns;
  logic p_scl, p_sda;
  logic [11:0] run;
  logic [7:0] since_stop;
  wire logic ctl = !scl_oe && !p_scl;
  wire logic start_ev = ctl && sda_oe && !p_sda;
  wire logic stop_ev = ctl && !sda_oe && p_sda;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      p_scl <= 1'b0;
      p_sda <= 1'b0;
      run <= 12'h0;
      since_stop <= 8'hFF;
    end else begin
      p_scl <= scl_oe;
      p_sda <= sda_oe;
      run <= (scl_oe != p_scl) ? 12'h1 : run + 12'h1;
      since_stop <= stop_ev ? 8'h0 : (since_stop == 8'hFF ? since_stop : since_stop + 8'h1);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_zero: assert property (avs_read && avs_address[2] && !avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_go_reads_zero: assert property (avs_read && avs_address == 3'h0 && !avs_waitrequest |-> !avs_readdata[0])
    else $error("go bit reads back set");
  a_pf_lockout: assert property (power_fail [*5] |-> !scl_oe && !sda_oe)
    else $error("bus lines driven during power fail");
  a_low_phase: assert property (disable iff (!nrst || power_fail)
    p_scl && !scl_oe |-> run == 12'(2 * QUART_CYC))
    else $error("clock low phase has wrong length");
  a_bus_free: assert property (start_ev |-> since_stop >= BUF_CYC)
    else $error("start too soon after stop");
  a_start_hold: assert property (start_ev |-> !scl_oe [*2])
    else $error("clock pulled right after start");
  a_stop_end: assert property (stop_ev |-> (!scl_oe && !sda_oe) [*4])
    else $error("bus driven right after stop");
  c_start: cover property (start_ev);
  c_stop: cover property (stop_ev);
  c_pf_abort: cover property (power_fail && scl_oe);
endmodule // srtc_host_asserts
bind srtc_host srtc_host_asserts #(.QUART_CYC(QUART_CYC), .BUF_CYC(BUF_CYC)) u_chk (
  .clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .power_fail(power_fail)
);
`default_nettype wire

// File: srtc_host_tb.sv
`default_nettype none
module srtc_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0;
  logic nrst = 0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, scl_o, scl_oe, sda_o, sda_oe, dev_pull;
  logic power_fail = 0;
  logic deaf = 0;
  wire logic scl_w = ~scl_oe;
  wire logic sda_w = ~(sda_oe | dev_pull);
  logic [7:0] ref_mem [64];
  logic [5:0] ref_ptr;
  logic [31:0] q;
  logic [7:0] b;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #25 clock = ~clock;
  srtc_host #(.QUART_CYC(4), .BUF_CYC(2)) i_dut (
    .clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .power_fail(power_fail)
  );
  srtc_dev_model i_dev (.scl(scl_w), .sda(sda_w), .power_fail(power_fail), .deaf(deaf), .pull(dev_pull));
  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ==========================================
  // avalon master cycle and operations
  task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic run_op(input logic rd, input logic sp, input logic [6:0] cnt, input logic [5:0] wa);
    logic [31:0] x;
    av(1, 3'h0, {10'h0, wa, 1'b0, cnt, 5'h0, sp, rd, 1'b1}, x);
    do av(0, 3'h1, 32'h0, q); while (q[1] !== 1'b1);
    av(1, 3'h1, 32'hE, x);
  endtask
  task automatic chk_buf(input int n, input logic [5:0] s);
    av(1, 3'h2, 32'h0, q);
    for (int i = 0; i < n; i++) begin
      av(0, 3'h3, 32'h0, q);
      chk("read byte", q[7:0], ref_mem[6'(s + i)]);
    end
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    for (int i = 0; i < 64; i++) ref_mem[i] = 8'(i * 37 + 11);
    {ref_mem[0], ref_mem[1], ref_mem[2], ref_mem[3]} = 32'h59_59_23_07;
    {ref_mem[4], ref_mem[5], ref_mem[6], ref_mem[7]} = 32'h31_12_99_80;
    void'($urandom(21432));
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    av(0, 3'h5, 32'h0, q);
    chk("unmapped", q, 32'h0);
    av(0, 3'h0, 32'h0, q);
    chk("go bit", q[0], 1'b0);
    av(1, 3'h2, 32'h0, q);
    for (int i = 0; i < 6; i++) begin
      b = 8'($urandom);
      ref_mem[6'(60 + i)] = b;
      av(1, 3'h3, {24'h0, b}, q);
    end
    run_op(0, 0, 7'd6, 6'd60);
    ref_ptr = 6'h2;
    chk("write status", {q[13:8], q[4:0]}, {ref_ptr, 5'h02});
    av(0, 3'h0, 32'h0, q);
    chk("ctrl readback", q, {10'h0, 6'd60, 1'b0, 7'd6, 8'h00});
    run_op(1, 1, 7'd64, 6'd0);
    ref_ptr = 6'h3F;
    chk("read status", {q[13:8], q[4:0]}, {ref_ptr, 5'h02});
    chk_buf(64, 6'd0);
    av(0, 3'h2, 32'h0, q);
    chk("buffer index", q, 32'h0);
    run_op(1, 0, 7'd3, 6'd0);
    ref_ptr = 6'h1;
    chk("held ptr status", {q[13:8], q[4:0]}, {ref_ptr, 5'h02});
    chk_buf(3, 6'd63);
    run_op(0, 0, 7'd0, 6'd7);
    ref_ptr = 6'h7;
    chk("set ptr status", {q[13:8], q[4:0]}, {ref_ptr, 5'h02});
    run_op(1, 0, 7'd1, 6'd0);
    chk("last byte status", {q[13:8], q[4:0]}, {ref_ptr, 5'h02});
    chk_buf(1, 6'd7);
    // power fail in the middle of a read
    av(1, 3'h0, {10'h0, 6'd20, 1'b0, 7'd10, 8'h07}, q);
    repeat (600) @(posedge clock);
    power_fail <= 1'b1;
    repeat (10) @(posedge clock);
    av(0, 3'h1, 32'h0, q);
    ref_ptr = 6'h0;
    chk("abort status", {q[13:8], q[4:0]}, {ref_ptr, 5'h1A});
    power_fail <= 1'b0;
    av(1, 3'h1, 32'hE, q);
    repeat (4) @(posedge clock);
    run_op(1, 0, 7'd1, 6'd0);
    chk_buf(1, 6'd0);
    deaf <= 1'b1;
    run_op(0, 0, 7'd1, 6'd5);
    chk("nack status", {q[13:8], q[4:0]}, {ref_ptr, 5'h06});
    chk("open drain levels", {30'h0, scl_o, sda_o}, 32'h0);
    stop_test();
  end
endmodule // srtc_host_tb
`default_nettype wire
